// file: design/core_exec_regs.svh
// register offsets, field positions, reset values and encodings of the execute block
// assumes: included by bare name from the design files and the testbench
`ifndef CORE_EXEC_REGS_SVH
`define CORE_EXEC_REGS_SVH

// ---------------------------------------------------------------
// register byte offsets on the bus
// ---------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_WREG 8'h04
`define OFS_BANK 8'h08
`define OFS_PTR2 8'h0c
`define OFS_STATUS 8'h10
`define OFS_PC 8'h14
`define OFS_INSTR 8'h18

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CTRL_RUN 0
`define CTRL_EXT 1
`define ST_C 0
`define ST_DC 1
`define ST_Z 2
`define ST_OV 3
`define ST_N 4

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_CTRL 2'h0
`define RST_BYTE 8'h00
`define RST_BANK 4'h0
`define RST_PTR2 12'h000
`define RST_STATUS 5'h00
`define RST_PC 16'h0000
`define RST_INSTR 16'hffff

// ---------------------------------------------------------------
// addressing figures and the set-all data value
// ---------------------------------------------------------------
`define IDX_LIMIT 8'h5f
`define ACC_HI_BANK 4'hf
`define PC_STEP 16'h0002
`define SET_ALL 8'hff

`endif

// file: design/core_exec_pkg.sv
// types shared by the execute block
// assumes: nothing, not even the regs header
package core_exec_pkg;

	// gray codes along Q1 -> Q2 -> Q3 -> Q4 -> Q1
	typedef enum logic [1:0] {
		PH_Q1 = 2'b00,
		PH_Q2 = 2'b01,
		PH_Q3 = 2'b11,
		PH_Q4 = 2'b10
	} phase_t;

	typedef enum logic [2:0] {
		OP_NOP,
		OP_ADD_LIT,
		OP_ADD_REG,
		OP_BIT_SET,
		OP_SET_ALL,
		OP_BRANCH
	} op_t;

endpackage : core_exec_pkg

// file: design/byte_adder.sv
// 8-bit adder with the five arithmetic flags
// assumes: purely combinational, used by the execute block
`timescale 1ns/100ps
`include "core_exec_regs.svh"
module byte_adder (
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	output logic [7:0] sum,
	output logic [4:0] flags
);
	logic [8:0] full;
	logic [4:0] low;

	always_comb begin
		full = {1'b0, a} + {1'b0, b};
		low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
		sum = full[7:0];
		flags = '0;
		flags[`ST_C] = full[8];
		flags[`ST_DC] = low[4];
		flags[`ST_Z] = (full[7:0] == 8'h00);
		// overflow: both operands share a sign the sum does not
		flags[`ST_OV] = (a[7] == b[7]) && (full[7] != a[7]);
		flags[`ST_N] = full[7];
	end

endmodule : byte_adder

// file: design/byte_bit_branch_exec.sv
// decode and execute for the add, bit-set, set-all and relative branch subset
// assumes: program memory answers prog_addr within one clock; data memory reads combinationally
//
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "core_exec_regs.svh"

// Overview of operation
// - add accumulator to register sums working and addressed register, updates flags, one cycle
// - destination bit 0 writes working register, bit 1 writes addressed register
// - access bit 0 uses access bank, 1 uses bank select register
// - indexed mode when access bit 0, extension on, and register field at most 95
// - branch loads counter plus 2 plus twice signed offset, second cycle idle
// - bit set forces chosen bit to one, flags unchanged, one cycle
// - indexed add reads pointer plus literal, result routed by destination bit
// - indexed bit set targets byte at pointer plus literal offset
// - indexed set-all writes all ones at pointer plus literal, flags unchanged
module byte_bit_branch_exec (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic [15:0] prog_addr,
	input wire logic [15:0] prog_data,
	output logic [11:0] data_addr,
	input wire logic [7:0] data_rdata,
	output logic [7:0] data_wdata,
	output logic data_we
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	core_exec_pkg::phase_t phase_r;
	core_exec_pkg::phase_t phase_nxt;
	core_exec_pkg::op_t op;
	logic [1:0] ctrl_r;
	logic [7:0] wreg_r;
	logic [3:0] bank_r;
	logic [11:0] ptr2_r;
	logic [4:0] status_r;
	logic [15:0] pc_r;
	logic [15:0] pc_nxt;
	logic [15:0] instr_r;
	logic [7:0] opnd_r;
	logic [11:0] data_addr_r;
	logic [7:0] data_wdata_r;
	logic data_we_r;
	logic idle_cycle_r;
	logic ap_valid_r;
	logic ap_write_r;
	logic [7:0] ap_addr_r;
	logic [31:0] hrdata_r;
	logic run;
	logic step;
	logic bus_wr;
	logic ap_take;
	logic [7:0] add_b;
	logic [7:0] sum;
	logic [4:0] sum_flags;
	logic [7:0] result;
	logic to_mem;
	logic to_wreg;
	logic [7:0] bit_mask;

	// ---------------------------------------------------------------
	// functions
	// ---------------------------------------------------------------
	function automatic core_exec_pkg::op_t decode_op(input logic [15:0] iw);
		core_exec_pkg::op_t o;
		o = core_exec_pkg::OP_NOP;
		if (iw[15:8] == 8'h0f)
			o = core_exec_pkg::OP_ADD_LIT;
		else if (iw[15:10] == 6'b001001)
			o = core_exec_pkg::OP_ADD_REG;
		else if (iw[15:12] == 4'b1000)
			o = core_exec_pkg::OP_BIT_SET;
		else if (iw[15:9] == 7'b0110100)
			o = core_exec_pkg::OP_SET_ALL;
		else if (iw[15:11] == 5'b11010)
			o = core_exec_pkg::OP_BRANCH;
		return o;
	endfunction : decode_op

	function automatic logic is_indexed(input logic [15:0] iw, input logic ext);
		return !iw[8] && ext && (iw[7:0] <= `IDX_LIMIT);
	endfunction : is_indexed

	// data address of a byte or bit operand
	function automatic logic [11:0] eff_addr(input logic [15:0] iw, input logic [3:0] bank,
		input logic [11:0] ptr2, input logic ext);
		logic [11:0] ea;
		if (is_indexed(iw, ext))
			ea = ptr2 + {4'h0, iw[7:0]};
		else if (iw[8])
			ea = {bank, iw[7:0]};
		else if (iw[7])
			ea = {`ACC_HI_BANK, iw[7:0]};
		else
			ea = {4'h0, iw[7:0]};
		return ea;
	endfunction : eff_addr

	function automatic logic [31:0] read_mux(input logic [7:0] a, input logic [1:0] ctrl,
		input logic [7:0] w, input logic [3:0] b, input logic [11:0] f2, input logic [4:0] st,
		input logic [15:0] pc, input logic [15:0] iw);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (a)
			`OFS_CTRL: v = {30'h0, ctrl};
			`OFS_WREG: v = {24'h0, w};
			`OFS_BANK: v = {28'h0, b};
			`OFS_PTR2: v = {20'h0, f2};
			`OFS_STATUS: v = {27'h0, st};
			`OFS_PC: v = {16'h0, pc};
			`OFS_INSTR: v = {16'h0, iw};
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction : read_mux

	// ---------------------------------------------------------------
	// bus slave: zero wait, okay only; stalls while the clock enable is low
	// ---------------------------------------------------------------
	assign hreadyout = clk_en;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;
	assign ap_take = hsel && htrans[1] && hready;
	assign bus_wr = clk_en && ap_valid_r && ap_write_r;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ap_valid_r <= 1'b0;
			ap_write_r <= 1'b0;
			ap_addr_r <= 8'h00;
			hrdata_r <= 32'h0000_0000;
		end else if (clk_en) begin
			ap_valid_r <= ap_take;
			ap_write_r <= hwrite;
			ap_addr_r <= {haddr[7:2], 2'b00};
			// read data sampled at the address phase; whole-word transfers only
			if (ap_take && !hwrite)
				hrdata_r <= read_mux({haddr[7:2], 2'b00}, ctrl_r, wreg_r, bank_r, ptr2_r,
					status_r, pc_r, instr_r);
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			ctrl_r <= `RST_CTRL;
		else if (bus_wr && ap_addr_r == `OFS_CTRL)
			ctrl_r <= hwdata[1:0];
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			bank_r <= `RST_BANK;
			ptr2_r <= `RST_PTR2;
		end else if (bus_wr) begin
			if (ap_addr_r == `OFS_BANK)
				bank_r <= hwdata[3:0];
			if (ap_addr_r == `OFS_PTR2)
				ptr2_r <= hwdata[11:0];
		end
	end

	// ---------------------------------------------------------------
	// phase sequencer
	// ---------------------------------------------------------------
	assign run = ctrl_r[`CTRL_RUN];
	assign step = clk_en && run;

	always_comb begin
		unique case (phase_r)
			core_exec_pkg::PH_Q1: phase_nxt = core_exec_pkg::PH_Q2;
			core_exec_pkg::PH_Q2: phase_nxt = core_exec_pkg::PH_Q3;
			core_exec_pkg::PH_Q3: phase_nxt = core_exec_pkg::PH_Q4;
			core_exec_pkg::PH_Q4: phase_nxt = core_exec_pkg::PH_Q1;
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			phase_r <= core_exec_pkg::PH_Q1;
		else if (step)
			phase_r <= phase_nxt;
	end

	// ---------------------------------------------------------------
	// decode and operand fetch
	// ---------------------------------------------------------------
	assign prog_addr = pc_r;
	assign op = idle_cycle_r ? core_exec_pkg::OP_NOP : decode_op(instr_r);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			instr_r <= `RST_INSTR;
			data_addr_r <= 12'h000;
			opnd_r <= `RST_BYTE;
		end else if (step) begin
			if (phase_r == core_exec_pkg::PH_Q1) begin
				instr_r <= prog_data;
				data_addr_r <= eff_addr(prog_data, bank_r, ptr2_r, ctrl_r[`CTRL_EXT]);
			end
			if (phase_r == core_exec_pkg::PH_Q2)
				opnd_r <= data_rdata;
		end
	end

	// ---------------------------------------------------------------
	// data processing
	// ---------------------------------------------------------------
	assign add_b = (op == core_exec_pkg::OP_ADD_LIT) ? instr_r[7:0] : opnd_r;
	assign bit_mask = 8'h01 << instr_r[11:9];

	byte_adder u_adder (
		.a(wreg_r),
		.b(add_b),
		.sum(sum),
		.flags(sum_flags)
	);

	always_comb begin
		result = sum;
		to_mem = 1'b0;
		to_wreg = 1'b0;
		unique case (op)
			core_exec_pkg::OP_ADD_LIT: to_wreg = 1'b1;
			core_exec_pkg::OP_ADD_REG: begin
				to_mem = instr_r[9];
				to_wreg = !instr_r[9];
			end
			core_exec_pkg::OP_BIT_SET: begin
				result = opnd_r | bit_mask;
				to_mem = 1'b1;
			end
			core_exec_pkg::OP_SET_ALL: begin
				result = `SET_ALL;
				to_mem = 1'b1;
			end
			default: result = sum;
		endcase
	end

	// ---------------------------------------------------------------
	// write phase
	// ---------------------------------------------------------------
	assign data_addr = data_addr_r;
	assign data_wdata = data_wdata_r;
	assign data_we = data_we_r;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			data_we_r <= 1'b0;
			data_wdata_r <= `RST_BYTE;
		end else if (step) begin
			data_we_r <= (phase_r == core_exec_pkg::PH_Q3) && to_mem;
			if (phase_r == core_exec_pkg::PH_Q3)
				data_wdata_r <= result;
		end
	end

	// the core update wins over a bus write landing in the same cycle
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			wreg_r <= `RST_BYTE;
		else if (step && phase_r == core_exec_pkg::PH_Q4 && to_wreg)
			wreg_r <= sum;
		else if (bus_wr && ap_addr_r == `OFS_WREG)
			wreg_r <= hwdata[7:0];
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			status_r <= `RST_STATUS;
		else if (step && phase_r == core_exec_pkg::PH_Q4 && (op == core_exec_pkg::OP_ADD_LIT
			|| op == core_exec_pkg::OP_ADD_REG))
			status_r <= sum_flags;
		else if (bus_wr && ap_addr_r == `OFS_STATUS)
			status_r <= hwdata[4:0];
	end

	always_comb begin
		if (op == core_exec_pkg::OP_BRANCH)
			pc_nxt = pc_r + `PC_STEP + {{4{instr_r[10]}}, instr_r[10:0], 1'b0};
		else if (idle_cycle_r)
			pc_nxt = pc_r;
		else
			pc_nxt = pc_r + `PC_STEP;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pc_r <= `RST_PC;
			idle_cycle_r <= 1'b0;
		end else if (step && phase_r == core_exec_pkg::PH_Q4) begin
			pc_r <= pc_nxt;
			idle_cycle_r <= (op == core_exec_pkg::OP_BRANCH);
		end else if (bus_wr && ap_addr_r == `OFS_PC) begin
			pc_r <= {hwdata[15:1], 1'b0};
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_phase_walk;
		@(posedge sys_clk) disable iff (!reset_n)
		(step && phase_r == core_exec_pkg::PH_Q1) ##1 clk_en [*3] |-> phase_r == core_exec_pkg::PH_Q4;
	endproperty
	a_phase_walk: assert property (p_phase_walk) else $error("phases did not walk q1 to q4");

	property p_branch_target;
		@(posedge sys_clk) disable iff (!reset_n)
		(step && phase_r == core_exec_pkg::PH_Q4 && op == core_exec_pkg::OP_BRANCH)
		|=> pc_r == $past(pc_r) + 16'h0002 + {{4{instr_r[10]}}, instr_r[10:0], 1'b0} && idle_cycle_r;
	endproperty
	a_branch_target: assert property (p_branch_target) else $error("branch target wrong");

	property p_idle_quiet;
		@(posedge sys_clk) disable iff (!reset_n)
		idle_cycle_r |-> !data_we && !(step && phase_r == core_exec_pkg::PH_Q4 && to_wreg);
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("idle branch cycle did work");

	property p_dest_wreg;
		@(posedge sys_clk) disable iff (!reset_n)
		(step && phase_r == core_exec_pkg::PH_Q3 && op == core_exec_pkg::OP_ADD_REG && !instr_r[9])
		|=> !data_we && wreg_r == $past(wreg_r);
	endproperty
	a_dest_wreg: assert property (p_dest_wreg) else $error("d=0 add wrote memory");

	property p_indexed_addr;
		@(posedge sys_clk) disable iff (!reset_n)
		(phase_r == core_exec_pkg::PH_Q2 && is_indexed(instr_r, ctrl_r[`CTRL_EXT]))
		|-> data_addr == ptr2_r + {4'h0, instr_r[7:0]};
	endproperty
	a_indexed_addr: assert property (p_indexed_addr) else $error("indexed address wrong");

	property p_banked_addr;
		@(posedge sys_clk) disable iff (!reset_n)
		(phase_r == core_exec_pkg::PH_Q2 && instr_r[8]) |-> data_addr == {bank_r, instr_r[7:0]};
	endproperty
	a_banked_addr: assert property (p_banked_addr) else $error("banked address wrong");

	property p_bit_set;
		@(posedge sys_clk) disable iff (!reset_n)
		(step && phase_r == core_exec_pkg::PH_Q3 && op == core_exec_pkg::OP_BIT_SET)
		|=> data_we && data_wdata == ($past(opnd_r) | (8'h01 << $past(instr_r[11:9])));
	endproperty
	a_bit_set: assert property (p_bit_set) else $error("bit set data wrong");

	property p_set_all;
		@(posedge sys_clk) disable iff (!reset_n)
		(step && phase_r == core_exec_pkg::PH_Q3 && op == core_exec_pkg::OP_SET_ALL)
		|=> data_we && data_wdata == 8'hff && status_r == $past(status_r);
	endproperty
	a_set_all: assert property (p_set_all) else $error("set-all data wrong");

	property p_add_lit;
		@(posedge sys_clk) disable iff (!reset_n)
		(step && phase_r == core_exec_pkg::PH_Q4 && op == core_exec_pkg::OP_ADD_LIT)
		|=> wreg_r == $past(wreg_r) + $past(instr_r[7:0]) && status_r[`ST_Z] == (wreg_r == 8'h00);
	endproperty
	a_add_lit: assert property (p_add_lit) else $error("literal add wrong");

	property p_add_mem;
		@(posedge sys_clk) disable iff (!reset_n)
		(data_we && op == core_exec_pkg::OP_ADD_REG) |-> data_wdata == wreg_r + opnd_r;
	endproperty
	a_add_mem: assert property (p_add_mem) else $error("register add sum wrong");

endmodule : byte_bit_branch_exec

// file: verif/exec_memory_model.sv
// program memory and banked data memory seen by the execute block
// assumes: answers combinationally, writes land on the rising edge while data_we is high
`timescale 1ns/100ps
module exec_memory_model (
	input wire logic sys_clk,
	input wire logic [15:0] prog_addr,
	output logic [15:0] prog_data,
	input wire logic [11:0] data_addr,
	output logic [7:0] data_rdata,
	input wire logic [7:0] data_wdata,
	input wire logic data_we
);
	// ---------------------------------------------------------------
	// storage
	// ---------------------------------------------------------------
	// blank program words are an undecoded opcode, so a runaway fetch idles
	logic [15:0] rom [0:255];
	logic [7:0] ram [0:4095];

	initial begin
		for (int i = 0; i < 256; i++) begin
			rom[i] = 16'hffff;
		end
		for (int i = 0; i < 4096; i++) begin
			ram[i] = 8'h00;
		end
	end

	// ---------------------------------------------------------------
	// ports
	// ---------------------------------------------------------------
	assign prog_data = rom[prog_addr[8:1]];
	assign data_rdata = ram[data_addr];

	// the strobe decides the write, so a stray data_wdata can never land
	always @(posedge sys_clk) begin
		if (data_we === 1'b1) begin
			ram[data_addr] <= data_wdata;
		end
	end
endmodule : exec_memory_model

// file: verif/byte_bit_branch_exec_tb.sv
// self-checking bench: register bus tasks, a small program, expected memory and registers
// assumes: the design answers the bus when clk_en is high; memory model beside it
`timescale 1ns/100ps
`include "core_exec_regs.svh"
module byte_bit_branch_exec_tb;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic clk_en = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hready;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic [15:0] prog_addr;
	logic [15:0] prog_data;
	logic [11:0] data_addr;
	logic [7:0] data_rdata;
	logic [7:0] data_wdata;
	logic data_we;
	logic [31:0] rd;
	int bad_count = 0;
	int n_checks = 0;
	int cycles = 0;

	always #20 sys_clk = ~sys_clk;
	assign hready = hreadyout;

	byte_bit_branch_exec DUT (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .prog_addr(prog_addr),
		.prog_data(prog_data), .data_addr(data_addr), .data_rdata(data_rdata),
		.data_wdata(data_wdata), .data_we(data_we));

	exec_memory_model mem_side (.sys_clk(sys_clk), .prog_addr(prog_addr), .prog_data(prog_data),
		.data_addr(data_addr), .data_rdata(data_rdata), .data_wdata(data_wdata), .data_we(data_we));

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
			bad_count++;
		end
	endtask : check

	// entered just after a rising edge; hready is sampled at each edge
	task automatic bus_xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		hsize <= 3'h2;
		@(posedge sys_clk);
		while (hready !== 1'b1) @(posedge sys_clk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge sys_clk);
		while (hready !== 1'b1) @(posedge sys_clk);
		rd = hrdata;
		check({31'h0, hresp}, 32'h0);
	endtask : bus_xfer

	task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
		bus_xfer(1'b0, a, 32'h0);
		check(rd, exp);
	endtask : reg_read

	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : close_out

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			bad_count++;
			close_out();
		end
	end

	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial begin
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		reg_read(`OFS_CTRL, 32'h0);
		reg_read(`OFS_WREG, 32'h0);
		reg_read(`OFS_STATUS, 32'h0);
		reg_read(`OFS_PC, 32'h0);
		reg_read(`OFS_INSTR, 32'h0000ffff);
		bus_xfer(1'b1, 8'h1c, 32'hffffffff);
		reg_read(8'h1c, 32'h0);
		$display("reset values and unmapped offset done");

		// program: literal add, indexed add to W, banked add to f, bit sets, set-all, access add
		mem_side.rom[0] = 16'h0f10;
		mem_side.rom[1] = 16'h242c;
		mem_side.rom[2] = 16'h2740;
		mem_side.rom[3] = 16'h8e0a;
		mem_side.rom[4] = 16'h8141;
		mem_side.rom[5] = 16'h6830;
		mem_side.rom[6] = 16'h2490;
		mem_side.rom[7] = 16'h0fb8;
		mem_side.rom[8] = 16'hd7ff;
		mem_side.ram[12'ha2c] = 8'h20;
		mem_side.ram[12'h340] = 8'hc2;
		mem_side.ram[12'ha0a] = 8'h55;
		mem_side.ram[12'h341] = 8'h0a;
		mem_side.ram[12'hf90] = 8'h01;
		bus_xfer(1'b1, `OFS_WREG, 32'h00000017);
		bus_xfer(1'b1, `OFS_BANK, 32'h00000003);
		bus_xfer(1'b1, `OFS_PTR2, 32'hfffffa00);
		reg_read(`OFS_PTR2, 32'h00000a00);
		reg_read(`OFS_BANK, 32'h00000003);
		bus_xfer(1'b1, `OFS_CTRL, 32'h00000003);
		// a frozen stretch mid-program: the bus must stall and the run must still finish
		repeat (5) @(posedge sys_clk);
		clk_en <= 1'b0;
		repeat (6) @(posedge sys_clk);
		check({31'h0, hreadyout}, 32'h0);
		clk_en <= 1'b1;
		// nine instructions of four clocks each, then the branch to itself spins
		repeat (80) @(posedge sys_clk);
		check({24'h0, mem_side.ram[12'ha2c]}, 32'h20);
		check({24'h0, mem_side.ram[12'h340]}, 32'h09);
		check({24'h0, mem_side.ram[12'ha0a]}, 32'hd5);
		check({24'h0, mem_side.ram[12'h341]}, 32'h0b);
		check({24'h0, mem_side.ram[12'ha30]}, 32'hff);
		check({24'h0, mem_side.ram[12'hf90]}, 32'h01);
		check({24'h0, mem_side.ram[12'h030]}, 32'h00);
		reg_read(`OFS_WREG, 32'h00000000);
		reg_read(`OFS_STATUS, 32'h00000007);
		reg_read(`OFS_PC, 32'h00000010);
		reg_read(`OFS_INSTR, 32'h0000d7ff);
		$display("program run done");
		close_out();
	end
endmodule : byte_bit_branch_exec_tb
